// ===== design/siu_pkg.sv
// Constants shared by the six-source two-level interrupt unit
package siu_pkg;

   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
   localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
   localparam logic [7:0] ADDR_INT_ENABLE = 8'ha8;
   localparam logic [7:0] ADDR_PRIORITY = 8'hb8;
   localparam logic [7:0] ADDR_ADC_REQUEST = 8'hc0;

   // ==========================================================
   // Field positions
   localparam int TC_EXT0_SEL = 0;
   localparam int TC_EXT0_FLAG = 1;
   localparam int TC_EXT1_SEL = 2;
   localparam int TC_EXT1_FLAG = 3;
   localparam int TC_TIMER0_FLAG = 5;
   localparam int TC_TIMER1_FLAG = 7;
   localparam int SC_RX_FLAG = 0;
   localparam int SC_TX_FLAG = 1;
   localparam int EN_EXT0 = 0;
   localparam int EN_TIMER0 = 1;
   localparam int EN_EXT1 = 2;
   localparam int EN_TIMER1 = 3;
   localparam int EN_SERIAL = 4;
   localparam int EN_ADC = 6;
   localparam int EN_GLOBAL = 7;
   localparam int AR_ADC_FLAG = 0;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] ENABLE_MASK = 8'hdf;
   localparam logic [7:0] PRIORITY_MASK = 8'h3f;

   // ==========================================================
   // Sources in polling order, highest first
   localparam int NUM_SOURCES = 6;
   localparam logic [2:0] SRC_EXT0 = 3'h0;
   localparam logic [2:0] SRC_TIMER0 = 3'h1;
   localparam logic [2:0] SRC_EXT1 = 3'h2;
   localparam logic [2:0] SRC_TIMER1 = 3'h3;
   localparam logic [2:0] SRC_SERIAL = 3'h4;
   localparam logic [2:0] SRC_ADC = 3'h5;

   // ==========================================================
   // Vectors and converter timing in machine cycles
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   localparam logic [3:0] ADC_FLAG_CYCLE = 4'hb;
   localparam logic [3:0] ADC_CONV_CYCLES = 4'hf;
   localparam logic [3:0] ADC_FIRST_CYCLE = 4'h1;
   localparam logic [3:0] ADC_IDLE = 4'h0;

endpackage

// ===== design/siu_ext_trigger.sv
// External request flag with level or falling-edge trigger
`timescale 1ns/100ps
module siu_ext_trigger
   import siu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sys_ce,
   input wire logic pin,
   input wire logic edge_sel,
   input wire logic wr_en,
   input wire logic wr_val,
   input wire logic vec_clear,
   output logic flag
);

   logic prev_pin;

   // ==========================================================
   // Pin history for edge detection
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prev_pin <= 1'b1;
      end else if (sys_ce) begin
         prev_pin <= pin;
      end
   end

   // ==========================================================
   // Request flag
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         flag <= 1'b0;
      end else if (sys_ce) begin
         if (!edge_sel) begin
            // Level mode: the pin owns the flag, writes are ignored
            flag <= ~pin;
         end else if ((prev_pin && !pin) || (wr_en && wr_val)) begin
            // Set wins over any clear in the same cycle
            flag <= 1'b1;
         end else if (vec_clear || wr_en) begin
            flag <= 1'b0;
         end
      end
   end

endmodule

// ===== design/siu_priority_pick.sv
// Two-level priority selection with fixed polling order
`timescale 1ns/100ps
module siu_priority_pick
   import siu_pkg::*;
(
   input wire logic [5:0] cand,
   input wire logic [5:0] high,
   input wire logic [1:0] inprog,
   output logic found,
   output logic [2:0] sel,
   output logic lvl,
   output logic [5:0] lvl_set
);

   logic [5:0] elig_hi;
   logic [5:0] elig_lo;

   // High requests may interrupt only a low routine or none
   assign elig_hi = cand & high & {6{~inprog[1]}};
   assign elig_lo = cand & ~high & {6{~(inprog[1] | inprog[0])}};

   always_comb begin
      lvl = |elig_hi;
      lvl_set = lvl ? elig_hi : elig_lo;
      found = |lvl_set;
      sel = SRC_EXT0;
      // Scan down so the lowest index (earliest in polling) wins
      for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
         if (lvl_set[i]) begin
            sel = 3'(i);
         end
      end
   end

endmodule

// ===== design/siu_top.sv
// Interrupt request, enable and two-level priority unit
`timescale 1ns/100ps
// Contract
// - Six sources: two timers, serial, converter, two external pins.
// - Each source sets its flag regardless of enables; a set flag stays set until hardware or software clears it.
// - External request level or falling-edge by select bit in timer control.
// - Edge mode flag cleared on vectoring; level mode flag follows pin.
// - Timer flags set on rollover, cleared by hardware when vectored.
// - Serial request is receive OR transmit; hardware never clears them.
// - Converter flag set in 11th machine cycle of each conversion.
// - Enable bits: ext0 0, timer0 1, ext1 2, timer1 3, serial 4, adc 6.
// - Enable bit 7 is global; zero blocks all acknowledges.
// - Converter request register holds done flag at bit 0, rest reserved.
// - Software writes to flags act like hardware set or clear, except level-mode external flags, which ignore writes.
// - Each source has its own priority level bit.
// - Only a higher level may preempt a running routine.
// - Simultaneous different levels: high level serviced first.
// - Same level ties: ext0, timer0, ext1, timer1, serial order.
// - Converter is sixth in polling order, used only for ties.
// - Flags sampled each cycle, polled next; denied requests not remembered.
// - Accepted call goes to vector 0003h plus eight per source index.
// - Return-from-interrupt clears current level in-progress; plain return not.
module siu_top
   import siu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sys_ce,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic ext_request0_pin,
   input wire logic ext_request1_pin,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic serial_rx_done,
   input wire logic serial_tx_done,
   input wire logic conv_start,
   input wire logic conv_continuous,
   input wire logic instr_final,
   input wire logic instr_blocking,
   input wire logic return_from_interrupt,
   output logic call_req,
   output logic [15:0] call_vector,
   output logic [2:0] call_source,
   output logic call_level,
   output logic [1:0] in_progress
);

   // ==========================================================
   // Register port decode
   logic wr_tc;
   logic wr_sc;
   logic wr_ie;
   logic wr_ip;
   logic wr_ar;

   assign wr_tc = sys_ce && reg_wr && (reg_addr == ADDR_TIMER_CTRL);
   assign wr_sc = sys_ce && reg_wr && (reg_addr == ADDR_SERIAL_CTRL);
   assign wr_ie = sys_ce && reg_wr && (reg_addr == ADDR_INT_ENABLE);
   assign wr_ip = sys_ce && reg_wr && (reg_addr == ADDR_PRIORITY);
   assign wr_ar = sys_ce && reg_wr && (reg_addr == ADDR_ADC_REQUEST);

   logic [7:0] interrupt_enable_reg;
   logic [7:0] priority_level_reg;
   logic [1:0] ext_sel;
   logic [1:0] ext_flag;
   logic [1:0] timer_flag;
   logic serial_receive_flag;
   logic serial_transmit_flag;
   logic converter_done_flag;
   logic [3:0] conv_cnt;
   logic [5:0] src_flag;
   logic [5:0] samp;
   logic [5:0] en_vec;
   logic [5:0] cand;
   logic found;
   logic [2:0] sel;
   logic lvl;
   logic [5:0] lvl_set;
   logic accept;

   // ==========================================================
   // Enable, priority and trigger-select registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         interrupt_enable_reg <= REG_RESET;
      end else if (wr_ie) begin
         interrupt_enable_reg <= reg_wdata & ENABLE_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         priority_level_reg <= REG_RESET;
      end else if (wr_ip) begin
         priority_level_reg <= reg_wdata & PRIORITY_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ext_sel <= 2'h0;
      end else if (wr_tc) begin
         ext_sel <= {reg_wdata[TC_EXT1_SEL], reg_wdata[TC_EXT0_SEL]};
      end
   end

   // ==========================================================
   // Request flags
   logic [1:0] ext_pin;
   logic [1:0] ext_wval;
   logic [1:0] tmr_event;
   logic [1:0] tmr_wval;
   logic [2:0] ext_src [2];
   logic [2:0] tmr_src [2];

   assign ext_pin = {ext_request1_pin, ext_request0_pin};
   assign ext_wval = {reg_wdata[TC_EXT1_FLAG], reg_wdata[TC_EXT0_FLAG]};
   assign tmr_event = {timer1_overflow, timer0_overflow};
   assign tmr_wval = {reg_wdata[TC_TIMER1_FLAG], reg_wdata[TC_TIMER0_FLAG]};
   assign ext_src[0] = SRC_EXT0;
   assign ext_src[1] = SRC_EXT1;
   assign tmr_src[0] = SRC_TIMER0;
   assign tmr_src[1] = SRC_TIMER1;

   for (genvar g = 0; g < 2; g++) begin : g_pair
      siu_ext_trigger u_ext (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .sys_ce(sys_ce),
         .pin(ext_pin[g]),
         .edge_sel(ext_sel[g]),
         .wr_en(wr_tc),
         .wr_val(ext_wval[g]),
         .vec_clear(accept && (sel == ext_src[g])),
         .flag(ext_flag[g])
      );

      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            timer_flag[g] <= 1'b0;
         end else if (sys_ce) begin
            if (tmr_event[g] || (wr_tc && tmr_wval[g])) begin
               timer_flag[g] <= 1'b1;
            end else if ((accept && (sel == tmr_src[g])) || wr_tc) begin
               timer_flag[g] <= 1'b0;
            end
         end
      end
   end

   // Serial flags are never touched by vectoring
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         serial_receive_flag <= 1'b0;
      end else if (sys_ce) begin
         if (serial_rx_done || (wr_sc && reg_wdata[SC_RX_FLAG])) begin
            serial_receive_flag <= 1'b1;
         end else if (wr_sc) begin
            serial_receive_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         serial_transmit_flag <= 1'b0;
      end else if (sys_ce) begin
         if (serial_tx_done || (wr_sc && reg_wdata[SC_TX_FLAG])) begin
            serial_transmit_flag <= 1'b1;
         end else if (wr_sc) begin
            serial_transmit_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Converter cycle counter; a new start restarts the count
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         conv_cnt <= ADC_IDLE;
      end else if (sys_ce) begin
         if (conv_start) begin
            conv_cnt <= ADC_FIRST_CYCLE;
         end else if (conv_cnt == ADC_CONV_CYCLES) begin
            conv_cnt <= conv_continuous ? ADC_FIRST_CYCLE : ADC_IDLE;
         end else if (conv_cnt != ADC_IDLE) begin
            conv_cnt <= conv_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         converter_done_flag <= 1'b0;
      end else if (sys_ce) begin
         if ((conv_cnt == ADC_FLAG_CYCLE) || (wr_ar && reg_wdata[AR_ADC_FLAG])) begin
            converter_done_flag <= 1'b1;
         end else if (wr_ar) begin
            converter_done_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Sampling, enables and selection
   assign src_flag = {converter_done_flag, serial_receive_flag | serial_transmit_flag,
                      timer_flag[1], ext_flag[1], timer_flag[0], ext_flag[0]};

   // Only the current sample is polled; nothing else is remembered
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         samp <= 6'h00;
      end else if (sys_ce) begin
         samp <= src_flag;
      end
   end

   assign en_vec = {interrupt_enable_reg[EN_ADC], interrupt_enable_reg[EN_SERIAL],
                    interrupt_enable_reg[EN_TIMER1], interrupt_enable_reg[EN_EXT1],
                    interrupt_enable_reg[EN_TIMER0], interrupt_enable_reg[EN_EXT0]};
   assign cand = samp & en_vec & {6{interrupt_enable_reg[EN_GLOBAL]}};

   siu_priority_pick u_pick (
      .cand(cand),
      .high(priority_level_reg[5:0]),
      .inprog(in_progress),
      .found(found),
      .sel(sel),
      .lvl(lvl),
      .lvl_set(lvl_set)
   );

   // Core must be at an instruction boundary and not in a blocking instruction
   assign accept = sys_ce && found && instr_final && !instr_blocking && !return_from_interrupt;

   // ==========================================================
   // In-progress state per level
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         in_progress <= 2'h0;
      end else if (accept) begin
         in_progress[lvl] <= 1'b1;
      end else if (sys_ce && return_from_interrupt) begin
         if (in_progress[1]) begin
            in_progress[1] <= 1'b0;
         end else begin
            in_progress[0] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Call request to the core
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         call_req <= 1'b0;
         call_vector <= 16'h0000;
         call_source <= SRC_EXT0;
         call_level <= 1'b0;
      end else if (sys_ce) begin
         call_req <= accept;
         if (accept) begin
            call_vector <= 16'(VEC_BASE + VEC_STEP * {13'h0000, sel});
            call_source <= sel;
            call_level <= lvl;
         end
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= REG_RESET;
      end else if (sys_ce) begin
         reg_rdata <= REG_RESET;
         if (reg_rd) begin
            case (reg_addr)
               ADDR_TIMER_CTRL: begin
                  reg_rdata[TC_EXT0_SEL] <= ext_sel[0];
                  reg_rdata[TC_EXT0_FLAG] <= ext_flag[0];
                  reg_rdata[TC_EXT1_SEL] <= ext_sel[1];
                  reg_rdata[TC_EXT1_FLAG] <= ext_flag[1];
                  reg_rdata[TC_TIMER0_FLAG] <= timer_flag[0];
                  reg_rdata[TC_TIMER1_FLAG] <= timer_flag[1];
               end
               ADDR_SERIAL_CTRL: begin
                  reg_rdata[SC_RX_FLAG] <= serial_receive_flag;
                  reg_rdata[SC_TX_FLAG] <= serial_transmit_flag;
               end
               ADDR_INT_ENABLE: begin
                  reg_rdata <= interrupt_enable_reg;
               end
               ADDR_PRIORITY: begin
                  reg_rdata <= priority_level_reg;
               end
               ADDR_ADC_REQUEST: begin
                  reg_rdata[AR_ADC_FLAG] <= converter_done_flag;
               end
               default: begin
                  reg_rdata <= REG_RESET;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // Cycles since the last start, counted apart from the converter's own counter
   logic [3:0] conv_age;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         conv_age <= ADC_IDLE;
      end else if (sys_ce && conv_start) begin
         conv_age <= ADC_FIRST_CYCLE;
      end else if (sys_ce && (conv_age != ADC_IDLE)) begin
         conv_age <= conv_age + 4'h1;
      end
   end

   sequence s_conv_eleventh;
      sys_ce && (conv_age == ADC_FLAG_CYCLE);
   endsequence

   a_adc_eleventh: assert property (
      s_conv_eleventh |=> converter_done_flag)
      else $error("converter flag not set in eleventh cycle");

   a_timer_set: assert property (
      sys_ce && timer0_overflow |=> timer_flag[0] ##1 (timer_flag[0] || $past(accept)
      || $past(wr_tc)))
      else $error("timer flag lost after overflow");

   a_timer_vec_clear: assert property (
      accept && (sel == SRC_TIMER1) && !timer1_overflow && !wr_tc |=> !timer_flag[1])
      else $error("timer flag not cleared on vectoring");

   a_serial_kept: assert property (
      accept && (sel == SRC_SERIAL) && src_flag[SRC_SERIAL] && !wr_sc |=> src_flag[SRC_SERIAL])
      else $error("serial flag cleared by vectoring");

   a_level_follow: assert property (
      sys_ce && !ext_sel[0] |=> ext_flag[0] == !$past(ext_request0_pin))
      else $error("level flag does not follow pin");

   a_global_gate: assert property (
      accept |-> interrupt_enable_reg[EN_GLOBAL] && en_vec[sel] && samp[sel])
      else $error("call accepted while disabled");

   a_high_first: assert property (
      accept && |(cand & priority_level_reg[5:0]) && !in_progress[1] |-> lvl)
      else $error("low level chosen over high level");

   a_no_preempt: assert property (
      accept |-> !in_progress[1] && (lvl || !in_progress[0]))
      else $error("equal or lower level preempted");

   a_poll_order: assert property (
      accept |-> (lvl_set & ((6'h01 << sel) - 6'h01)) == 6'h00)
      else $error("polling order violated");

   a_call_vector: assert property (
      accept |=> call_req && (call_vector == 16'(VEC_BASE + VEC_STEP * {13'h0000, $past(sel)})))
      else $error("wrong call vector");

   a_return_from_interrupt_clear: assert property (
      sys_ce && return_from_interrupt && in_progress[1] |=> !in_progress[1] ##1 1'b1)
      else $error("return did not clear in-progress level");

endmodule

// ===== verification/siu_core_model.sv
// CPU core stand-in that drives instruction boundaries and returns
`timescale 1ns/100ps
module siu_core_model
   import siu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic call_req,
   output logic instr_final,
   output logic instr_blocking,
   output logic return_from_interrupt,
   output logic [7:0] call_count
);
   // ==========================================================
   // Instruction boundary control, high from the start so every cycle ends an instruction until set_core drives it low
   initial begin
      instr_final = 1'b1;
      instr_blocking = 1'b0;
      return_from_interrupt = 1'b0;
   end

   task automatic set_core(input logic fin, input logic blk);
      @(posedge sys_clk);
      instr_final <= fin;
      instr_blocking <= blk;
   endtask

   // Return lasts one machine cycle
   task automatic do_return();
      @(posedge sys_clk);
      return_from_interrupt <= 1'b1;
      @(posedge sys_clk);
      return_from_interrupt <= 1'b0;
   endtask

   // ==========================================================
   // Count the vectored calls the core has taken
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         call_count <= 8'h00;
      end else if (call_req) begin
         call_count <= call_count + 8'h01;
      end
   end
endmodule

// ===== verification/tb_top.sv
// Self-checking testbench for the interrupt unit
`timescale 1ns/100ps
module tb_top
   import siu_pkg::*;
;
   logic sys_clk;
   logic sys_rst;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic pin0;
   logic pin1;
   logic [4:0] ev;
   logic cont;
   logic instr_final;
   logic instr_blocking;
   logic return_from_interrupt;
   logic call_req;
   logic [15:0] call_vector;
   logic [2:0] call_source;
   logic call_level;
   logic [1:0] in_progress;
   logic [7:0] call_count;
   int n_mismatch = 0;
   int n_compared = 0;

   // ==========================================================
   // Clock, design and core model
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   siu_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_request0_pin(pin0), .ext_request1_pin(pin1), .timer0_overflow(ev[0]),
      .timer1_overflow(ev[1]), .serial_rx_done(ev[2]), .serial_tx_done(ev[3]),
      .conv_start(ev[4]), .conv_continuous(cont), .instr_final(instr_final),
      .instr_blocking(instr_blocking), .return_from_interrupt(return_from_interrupt),
      .call_req(call_req), .call_vector(call_vector), .call_source(call_source),
      .call_level(call_level), .in_progress(in_progress));

   siu_core_model core (.sys_clk(sys_clk), .sys_rst(sys_rst), .call_req(call_req),
      .instr_final(instr_final), .instr_blocking(instr_blocking),
      .return_from_interrupt(return_from_interrupt), .call_count(call_count));

   // ==========================================================
   // Shared tasks
   task automatic report_and_stop();
      $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask

   task automatic fire(input logic [4:0] m);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 5'h00;
   endtask

   task automatic wait_call(input logic [2:0] src, input logic lvl, input logic [1:0] ip);
      int i;
      for (i = 0; i < 30; i++) begin
         @(posedge sys_clk);
         #1;
         if (call_req === 1'b1) break;
      end
      if (i == 30) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, call_req, 1'b1);
         report_and_stop();
      end else begin
         chk(call_vector, VEC_BASE + VEC_STEP * src);
         chk({13'h0000, call_source}, {13'h0000, src});
         chk({13'h0000, call_level, in_progress}, {13'h0000, lvl, ip});
      end
   endtask

   task automatic no_call(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         chk({15'h0000, call_req}, 16'h0000);
      end
   endtask

   task automatic ret_chk(input logic [1:0] ip);
      core.do_return();
      #1;
      chk({14'h0000, in_progress}, {14'h0000, ip});
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pin0 = 1'b1;
      pin1 = 1'b1;
      ev = 5'h00;
      cont = 1'b0;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;

      rd(ADDR_TIMER_CTRL, 8'h00);
      rd(ADDR_INT_ENABLE, 8'h00);
      rd(ADDR_ADC_REQUEST, 8'h00);
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00);
      wr(ADDR_INT_ENABLE, 8'h7f);
      rd(ADDR_INT_ENABLE, 8'h5f);
      wr(ADDR_ADC_REQUEST, 8'hff);
      rd(ADDR_ADC_REQUEST, 8'h01);
      wr(ADDR_ADC_REQUEST, 8'h00);
      rd(ADDR_ADC_REQUEST, 8'h00);
      $display("test registers done");

      wr(ADDR_TIMER_CTRL, 8'h05);
      wr(ADDR_TIMER_CTRL, 8'h0f);
      fire(5'b00111);
      wr(ADDR_ADC_REQUEST, 8'h01);
      rd(ADDR_TIMER_CTRL, 8'haf);
      wr(ADDR_INT_ENABLE, 8'hdf);
      for (int s = 0; s < NUM_SOURCES; s++) begin
         wait_call(s[2:0], 1'b0, 2'b01);
         if (s == 4) begin
            rd(ADDR_SERIAL_CTRL, 8'h01);
            wr(ADDR_SERIAL_CTRL, 8'h00);
         end else if (s == 5) begin
            wr(ADDR_ADC_REQUEST, 8'h00);
         end
         ret_chk(2'b00);
      end
      rd(ADDR_TIMER_CTRL, 8'h05);
      fire(5'b01000);
      wait_call(SRC_SERIAL, 1'b0, 2'b01);
      rd(ADDR_SERIAL_CTRL, 8'h02);
      wr(ADDR_SERIAL_CTRL, 8'h00);
      ret_chk(2'b00);
      $display("test polling order done");

      wr(ADDR_INT_ENABLE, 8'h5f);
      wr(ADDR_PRIORITY, 8'hff);
      rd(ADDR_PRIORITY, 8'h3f);
      wr(ADDR_PRIORITY, 8'h20);
      fire(5'b00001);
      wr(ADDR_ADC_REQUEST, 8'h01);
      wr(ADDR_INT_ENABLE, 8'hdf);
      wait_call(SRC_ADC, 1'b1, 2'b10);
      wr(ADDR_ADC_REQUEST, 8'h00);
      no_call(8);
      ret_chk(2'b00);
      wait_call(SRC_TIMER0, 1'b0, 2'b01);
      wr(ADDR_ADC_REQUEST, 8'h01);
      wait_call(SRC_ADC, 1'b1, 2'b11);
      wr(ADDR_ADC_REQUEST, 8'h00);
      ret_chk(2'b01);
      ret_chk(2'b00);
      wr(ADDR_PRIORITY, 8'h00);
      $display("test priority done");

      wr(ADDR_INT_ENABLE, 8'h02);
      fire(5'b00001);
      no_call(6);
      rd(ADDR_TIMER_CTRL, 8'h25);
      wr(ADDR_INT_ENABLE, 8'h80);
      no_call(6);
      core.set_core(1'b1, 1'b1);
      wr(ADDR_INT_ENABLE, 8'h82);
      no_call(6);
      core.set_core(1'b0, 1'b0);
      no_call(4);
      core.set_core(1'b1, 1'b0);
      wait_call(SRC_TIMER0, 1'b0, 2'b01);
      ret_chk(2'b00);
      $display("test enables done");

      wr(ADDR_TIMER_CTRL, 8'h00);
      wr(ADDR_TIMER_CTRL, 8'h0a);
      rd(ADDR_TIMER_CTRL, 8'h00);
      wr(ADDR_INT_ENABLE, 8'h84);
      @(posedge sys_clk);
      pin1 <= 1'b0;
      wait_call(SRC_EXT1, 1'b0, 2'b01);
      rd(ADDR_TIMER_CTRL, 8'h08);
      @(posedge sys_clk);
      pin1 <= 1'b1;
      rd(ADDR_TIMER_CTRL, 8'h00);
      ret_chk(2'b00);
      no_call(5);
      wr(ADDR_TIMER_CTRL, 8'h01);
      wr(ADDR_INT_ENABLE, 8'h81);
      @(posedge sys_clk);
      pin0 <= 1'b0;
      wait_call(SRC_EXT0, 1'b0, 2'b01);
      rd(ADDR_TIMER_CTRL, 8'h01);
      ret_chk(2'b00);
      no_call(5);
      @(posedge sys_clk);
      pin0 <= 1'b1;
      $display("test external done");

      wr(ADDR_INT_ENABLE, 8'h00);
      cont <= 1'b1;
      fire(5'b10000);
      // Second pass is the next conversion of continuous mode
      repeat (2) begin
         repeat (9) @(posedge sys_clk);
         rd(ADDR_ADC_REQUEST, 8'h00);
         rd(ADDR_ADC_REQUEST, 8'h01);
         wr(ADDR_ADC_REQUEST, 8'h00);
      end
      cont <= 1'b0;
      chk({8'h00, call_count}, 16'h000d);
      $display("test converter done");
      report_and_stop();
   end
endmodule
